// ---- design/rx_alarm_irq.v ----
/*
 * Receive alarm-indication and idle detection with change-of-state
 * interrupts, far-end receive failure request and AXI4-Lite registers.
 * Assumes a framer supplies per-frame pattern flags as pins from
 * another domain and a host services the active-low interrupt.
 */
// Local design decision: the AXI4-Lite slave port.
// Summary of operation
// - Alarm-indication change interrupt fires on both declare and clear.
// - Alarm-indication declared after 63 frames carrying the pattern.
// - Alarm-indication cleared after 63 frames lacking the pattern.
// - Alarm-indication interrupt gated by enable register bit 5.
// - Writing 1 to an enable bit enables, 0 disables.
// - Alarm-indication change drives interrupt output low.
// - Enabled alarm-indication change sets status register bit 5.
// - Current alarm-indication state readable at state register bit 7.
// - Far-end receive failure sent while alarm-indication present.
// - Far-end receive failure stops when alarm-indication clears.
// - Idle change interrupt fires on both declare and clear.
// - Idle declared after 63 frames carrying the idle pattern.
// - Idle cleared after 63 frames without the idle pattern.
// - Idle interrupt gated by enable register bit 4.
// - Enabled idle change drives interrupt low and sets status bit 4.
// - Current idle state readable at state register bit 5.
`timescale 1ns/1ps
`include "alarm_consts.vh"

module rx_alarm_irq #(
    parameter FRAMES = `FRAMES_TO_CHANGE,
    parameter CNT_W  = 6
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        frame_strobe,
    input  wire        ais_pattern_in,
    input  wire        idle_pattern_in,
    output reg         far_end_receive_failure_q,
    output wire        irq_n,
    input  wire [11:0] s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [11:0] s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);

    // =================================================================
    // Input synchronisation and frame edge
    // =================================================================
    wire [2:0] pins_s;
    reg        strobe_prev_q;
    wire       frame_tick;

    pin_sync #(
        .W (3)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in ({frame_strobe, ais_pattern_in, idle_pattern_in}),
        .sync_q   (pins_s)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            strobe_prev_q <= 1'b0;
        end else begin
            strobe_prev_q <= pins_s[2];
        end
    end

    // Pattern flags are sampled with the rising edge of the strobe
    assign frame_tick = pins_s[2] & ~strobe_prev_q;

    // =================================================================
    // Condition detectors
    // =================================================================
    wire ais_state;
    wire ais_change;
    wire idle_state;
    wire idle_change;

    // Declare and clear both need a full run of frames
    pattern_persist #(
        .FRAMES (FRAMES),
        .CNT_W  (CNT_W)
    ) u_ais (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .frame_tick   (frame_tick),
        .pattern_seen (pins_s[1]),
        .state_q      (ais_state),
        .change_q     (ais_change)
    );

    // Same persistence for the idle pattern
    pattern_persist #(
        .FRAMES (FRAMES),
        .CNT_W  (CNT_W)
    ) u_idle (
        .aclk         (aclk),
        .aresetn      (aresetn),
        .frame_tick   (frame_tick),
        .pattern_seen (pins_s[0]),
        .state_q      (idle_state),
        .change_q     (idle_change)
    );

    // =================================================================
    // Far-end receive failure request
    // =================================================================
    always @(posedge aclk) begin
        if (!aresetn) begin
            far_end_receive_failure_q <= 1'b0;
        end else begin
            // Follows the condition in both directions
            far_end_receive_failure_q <= ais_state;
        end
    end

    // =================================================================
    // Interrupt enable and flags
    // =================================================================
    reg  [7:0] int_enable_q;
    reg  [7:0] int_flags_q;
    reg  [7:0] flags_d;
    wire [7:0] events;
    wire       flags_read;
    wire       enable_write;
    wire [7:0] line_state;
    wire [7:0] frame_status;

    // Both edges of each condition are events
    assign events = ({7'h00, ais_change} << `BIT_AIS)
                  | ({7'h00, idle_change} << `BIT_IDLE);

    always @* begin
        flags_d = int_flags_q;
        // Read clears, but a same-cycle event survives
        if (flags_read) begin
            flags_d = 8'h00;
        end
        // Only enabled events latch
        flags_d = flags_d | (events & int_enable_q);
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            int_flags_q <= `RST_INT_FLAGS;
        end else begin
            int_flags_q <= flags_d;
        end
    end

    // Low while an enabled flag pends
    assign irq_n = ~|(int_flags_q & int_enable_q);

    // Live state view
    assign line_state = ({7'h00, ais_state} << `BIT_STATE_AIS)
                      | ({7'h00, idle_state} << `BIT_STATE_IDLE);
    assign frame_status = {7'h00, far_end_receive_failure_q};

    // =================================================================
    // AXI4-Lite write channel
    // =================================================================
    reg        aw_held_q;
    reg        w_held_q;
    reg [11:0] awaddr_q;
    reg [7:0]  wdata_q;
    reg        wstrb0_q;
    wire       aw_take;
    wire       w_take;
    wire       wr_go;

    assign s_axi_awready = ~aw_held_q & ~s_axi_bvalid;
    assign s_axi_wready  = ~w_held_q & ~s_axi_bvalid;
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take  = s_axi_wvalid & s_axi_wready;
    assign wr_go   = aw_held_q & w_held_q;
    assign enable_write = wr_go & wstrb0_q
                        & (awaddr_q == `ADDR_INT_ENABLE);

    function is_mapped;
        input [11:0] addr;
        begin
            is_mapped = (addr == `ADDR_LINE_STATE)
                      | (addr == `ADDR_INT_ENABLE)
                      | (addr == `ADDR_INT_FLAGS)
                      | (addr == `ADDR_FRAME_STATUS);
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 12'h000;
            wdata_q      <= 8'h00;
            wstrb0_q     <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `AXI_RESP_OKAY;
            int_enable_q <= `RST_INT_ENABLE;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_mapped(awaddr_q) ? `AXI_RESP_OKAY
                                                    : `AXI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            // Each bit written as 1 enables, 0 disables
            if (enable_write) begin
                int_enable_q <= wdata_q;
            end
        end
    end

    // =================================================================
    // AXI4-Lite read channel
    // =================================================================
    wire ar_take;
    reg  [7:0] rd_mux;

    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_take       = s_axi_arvalid & s_axi_arready;
    // The flags clear when the read is taken, with the data captured
    assign flags_read = ar_take
                      & ({s_axi_araddr[11:2], 2'b00} == `ADDR_INT_FLAGS);

    always @* begin
        case ({s_axi_araddr[11:2], 2'b00})
            `ADDR_LINE_STATE:   rd_mux = line_state;
            `ADDR_INT_ENABLE:   rd_mux = int_enable_q;
            `ADDR_INT_FLAGS:    rd_mux = int_flags_q;
            `ADDR_FRAME_STATUS: rd_mux = frame_status;
            default:            rd_mux = 8'h00;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `AXI_RESP_OKAY;
        end else begin
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= {24'h000000, rd_mux};
                s_axi_rresp  <= is_mapped({s_axi_araddr[11:2], 2'b00})
                                ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Host duties after each change (far-end alarm message) are left
    // to software

endmodule

// ---- pkg/alarm_consts.vh ----
/*
 * Register offsets, field positions, reset values and counts for the
 * receive alarm interrupt block.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ALARM_CONSTS_VH
`define ALARM_CONSTS_VH

// =====================================================================
// Register indices and byte addresses
// =====================================================================
`define IDX_LINE_STATE      8'h10
`define IDX_INT_ENABLE      8'h12
`define IDX_INT_FLAGS       8'h13
`define IDX_FRAME_STATUS    8'h14
`define ADDR_LINE_STATE     12'h040
`define ADDR_INT_ENABLE     12'h048
`define ADDR_INT_FLAGS      12'h04C
`define ADDR_FRAME_STATUS   12'h050

// =====================================================================
// Field positions
// =====================================================================
`define BIT_AIS             5
`define BIT_IDLE            4
`define BIT_STATE_AIS       7
`define BIT_STATE_IDLE      5
`define BIT_FAR_END_RECEIVE_FAILURE_SENT       0

// =====================================================================
// Reset values and counts
// =====================================================================
`define RST_INT_ENABLE      8'h00
`define RST_INT_FLAGS       8'h00
`define FRAMES_TO_CHANGE    63
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// ---- design/pattern_persist.v ----
/*
 * Persistence filter for one receive line condition: the state flips
 * after a run of frames that all disagree with it.
 * Assumes frame_tick pulses once per frame on aclk; pattern_seen is
 * valid with it.
 */
`timescale 1ns/1ps

module pattern_persist #(
    parameter FRAMES = 63,
    parameter CNT_W  = 6
) (
    input  wire aclk,
    input  wire aresetn,
    input  wire frame_tick,
    input  wire pattern_seen,
    output reg  state_q,
    output reg  change_q
);

    reg  [CNT_W-1:0] run_q;
    wire             disagree;

    assign disagree = pattern_seen ^ state_q;

    // =================================================================
    // Run counter
    // =================================================================
    // Any agreeing frame restarts the run, so the frames must be
    // consecutive for the state to move.
    always @(posedge aclk) begin
        if (!aresetn) begin
            run_q    <= {CNT_W{1'b0}};
            state_q  <= 1'b0;
            change_q <= 1'b0;
        end else begin
            change_q <= 1'b0;
            if (frame_tick) begin
                if (!disagree) begin
                    run_q <= {CNT_W{1'b0}};
                end else if (run_q == FRAMES[CNT_W-1:0] - 1'b1) begin
                    run_q    <= {CNT_W{1'b0}};
                    state_q  <= ~state_q;
                    change_q <= 1'b1;
                end else begin
                    run_q <= run_q + 1'b1;
                end
            end
        end
    end

endmodule

// ---- design/pin_sync.v ----
/*
 * Two-flop synchroniser for a bundle of level inputs.
 * Assumes inputs arrive asynchronously to aclk.
 */
`timescale 1ns/1ps

module pin_sync #(
    parameter W = 3
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire [W-1:0] async_in,
    output reg  [W-1:0] sync_q
);

    reg [W-1:0] meta_q;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule

// ---- tb/rx_alarm_irq_chk.sv ----
/* Port-level assertions for rx_alarm_irq.
   Assumes the bind below attaches it to every rx_alarm_irq. */
`timescale 1ns/1ps
`include "alarm_consts.vh"

module rx_alarm_irq_chk (
    input wire        aclk, aresetn, frame_strobe,
    input wire        far_end_receive_failure_q, irq_n,
    input wire        s_axi_awvalid, s_axi_awready,
    input wire        s_axi_wvalid, s_axi_wready,
    input wire        s_axi_bvalid, s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid, s_axi_arready,
    input wire [11:0] s_axi_araddr,
    input wire        s_axi_rvalid, s_axi_rready,
    input wire [31:0] s_axi_rdata
);
// =========
// Cycles since the frame pin last rose, saturating
// =========
reg [3:0] since_q;
reg       fs_q;
always @(posedge aclk) begin
    fs_q <= frame_strobe;
    if (!aresetn)
        since_q <= 4'hF;
    else if (frame_strobe && !fs_q)
        since_q <= 4'h0;
    else if (since_q != 4'hF)
        since_q <= since_q + 4'h1;
end
default clocking cb @(posedge aclk); endclocking
default disable iff (!aresetn);
// Events reach the pins well inside eight cycles of a frame
a_irq_cause: assert property (
    $fell(irq_n) |-> since_q <= 4'h8) else $error("irq without frame");
a_far_end_receive_failure_cause: assert property (
    $changed(far_end_receive_failure_q) |-> since_q <= 4'h8)
    else $error("far-end failure moved without frame");
a_read_clears: assert property (
    s_axi_arvalid && s_axi_arready && since_q > 4'h8
    && s_axi_araddr == `ADDR_INT_FLAGS |=> irq_n)
    else $error("irq held after status read");
a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
a_read_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data not held");
a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write not answered");
a_write_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response not held");
a_busy_refuse: assert property (s_axi_bvalid || s_axi_rvalid |->
    !(s_axi_bvalid && s_axi_awready) && !(s_axi_rvalid && s_axi_arready))
    else $error("request taken while answering");
a_upper_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
c_irq: cover property ($fell(irq_n));
c_far_end_receive_failure: cover property ($rose(far_end_receive_failure_q));
c_clear: cover property ($rose(irq_n));
endmodule

bind rx_alarm_irq rx_alarm_irq_chk chk (.*);

// ---- tb/frame_source.sv ----
/* Framer-side model: sends frames with pattern flags.
   Assumes the bench calls send from one process only. */
`timescale 1ns/1ps

module frame_source (
    input  wire aclk,
    output reg  frame_strobe,
    output reg  ais_pattern_in,
    output reg  idle_pattern_in
);
initial begin
    frame_strobe = 1'b0;
    ais_pattern_in = 1'b0;
    idle_pattern_in = 1'b0;
end
// Flags settle two cycles before the strobe so the synchroniser
// never catches them changing together
task send(input integer n, input a, input i);
    integer k;
    begin
        for (k = 0; k < n; k = k + 1) begin
            @(posedge aclk);
            ais_pattern_in <= a;
            idle_pattern_in <= i;
            repeat (2) @(posedge aclk);
            frame_strobe <= 1'b1;
            repeat (2) @(posedge aclk);
            frame_strobe <= 1'b0;
        end
    end
endtask
endmodule

// ---- tb/rx_alarm_irq_bench.sv ----
/* Self-checking bench for rx_alarm_irq through AXI4-Lite.
   Assumes frame_source drives the frame pins. */
`timescale 1ns/1ps
`include "alarm_consts.vh"
`define CHK(nm, e, g) \
    n_tests = n_tests + 1; \
    if ((g) !== (e)) begin \
        miscompares = miscompares + 1; \
        $display("CHECK FAILED %s exp %h got %h", nm, e, g); \
    end

module rx_alarm_irq_bench;
reg         aclk, aresetn;
reg  [11:0] s_axi_awaddr, s_axi_araddr;
reg  [31:0] s_axi_wdata;
reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready;
reg         s_axi_arvalid, s_axi_rready;
wire        fstb, ais_in, idle_in, far_end_receive_failure, irq_n;
wire        awready, wready, bvalid, arready, rvalid;
wire [1:0]  bresp, rresp;
wire [31:0] rdata;
integer     miscompares = 0;
integer     n_tests = 0;
reg  [31:0] d;
reg  [1:0]  r;

// Short persistence keeps the run brief
rx_alarm_irq #(.FRAMES(4), .CNT_W(3)) uut (
    .aclk(aclk), .aresetn(aresetn), .frame_strobe(fstb),
    .ais_pattern_in(ais_in), .idle_pattern_in(idle_in),
    .far_end_receive_failure_q(far_end_receive_failure), .irq_n(irq_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(s_axi_rready));
frame_source fs (.aclk(aclk), .frame_strobe(fstb),
    .ais_pattern_in(ais_in), .idle_pattern_in(idle_in));

task test_done;
    begin
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    end
endtask

task tend(input integer k);
    $display("test %0d done", k);
endtask

// =========
// Bus tasks
// =========
// Handshakes are judged on values settled just after each edge, which
// are the ones the next edge samples
task wr(input [11:0] a, input [31:0] v, output [1:0] b);
    reg aw, w, ta, tw;
    begin
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        #1;
        while (aw || w) begin
            ta = aw && awready;
            tw = w && wready;
            @(posedge aclk);
            if (ta) begin
                aw = 1'b0;
                s_axi_awvalid <= 1'b0;
            end
            if (tw) begin
                w = 1'b0;
                s_axi_wvalid <= 1'b0;
            end
            #1;
        end
        while (!bvalid) begin
            @(posedge aclk);
            #1;
        end
        @(posedge aclk);
        b = bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    end
endtask

task rd(input [11:0] a, output [31:0] v, output [1:0] b);
    begin
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        #1;
        while (!arready) begin
            @(posedge aclk);
            #1;
        end
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        #1;
        while (!rvalid) begin
            @(posedge aclk);
            #1;
        end
        @(posedge aclk);
        v = rdata;
        b = rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    end
endtask

task rchk(input [11:0] a, input [31:0] e);
    begin
        rd(a, d, r);
        `CHK("rdata", e, d)
        `CHK("rresp", `AXI_RESP_OKAY, r)
    end
endtask

// Six cycles cover the synchroniser and flag latency
task fr(input integer n, input a, input i);
    begin
        fs.send(n, a, i);
        repeat (6) @(posedge aclk);
    end
endtask

initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
end

initial begin
    repeat (5000) @(posedge aclk);
    miscompares = miscompares + 1;
    test_done;
end

initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_awvalid = 1'b0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(`ADDR_INT_ENABLE, 32'h00000000);
    rchk(`ADDR_INT_FLAGS, 32'h00000000);
    rchk(`ADDR_LINE_STATE, 32'h00000000);
    rd(12'hFFC, d, r);
    `CHK("unmapped", `AXI_RESP_SLVERR, r)
    tend(1);
    wr(`ADDR_INT_ENABLE, 32'h00000030, r);
    rchk(`ADDR_INT_ENABLE, 32'h00000030);
    fr(3, 1'b1, 1'b0);
    `CHK("irq_n", 1'b1, irq_n)
    fr(1, 1'b1, 1'b0);
    `CHK("irq_n", 1'b0, irq_n)
    `CHK("far_end_receive_failure", 1'b1, far_end_receive_failure)
    rchk(`ADDR_LINE_STATE, 32'h00000080);
    rchk(`ADDR_INT_FLAGS, 32'h00000020);
    `CHK("irq_n", 1'b1, irq_n)
    rchk(`ADDR_INT_FLAGS, 32'h00000000);
    tend(2);
    fr(3, 1'b0, 1'b0);
    rchk(`ADDR_LINE_STATE, 32'h00000080);
    fr(1, 1'b0, 1'b0);
    `CHK("irq_n", 1'b0, irq_n)
    `CHK("far_end_receive_failure", 1'b0, far_end_receive_failure)
    rchk(`ADDR_LINE_STATE, 32'h00000000);
    rchk(`ADDR_INT_FLAGS, 32'h00000020);
    tend(3);
    fr(4, 1'b0, 1'b1);
    `CHK("irq_n", 1'b0, irq_n)
    rchk(`ADDR_LINE_STATE, 32'h00000020);
    rchk(`ADDR_INT_FLAGS, 32'h00000010);
    fr(4, 1'b0, 1'b0);
    rchk(`ADDR_LINE_STATE, 32'h00000000);
    rchk(`ADDR_INT_FLAGS, 32'h00000010);
    tend(4);
    wr(`ADDR_INT_ENABLE, 32'h00000000, r);
    fr(4, 1'b1, 1'b1);
    `CHK("irq_n", 1'b1, irq_n)
    rchk(`ADDR_LINE_STATE, 32'h000000A0);
    rchk(`ADDR_INT_FLAGS, 32'h00000000);
    fr(4, 1'b0, 1'b0);
    `CHK("far_end_receive_failure", 1'b0, far_end_receive_failure)
    tend(5);
    test_done;
end
endmodule
